// *** ulc_pkg.sv ***
// Contract
// - Bank bit swaps offsets 0,1 to divisor
// - Bits 1:0 select five to eight bits
// - Bit 2 gives 1, 1.5 or 2 stops
// - Receiver checks only first stop bit
// - Bit 3 adds parity after last data
// - Bit 4 chooses odd or even parity
// - Stick parity forces fixed parity bit value
// - Bit 6 forces serial pin to zero
// - Break leaves transmitter timing running
// - Line control reads back all bits
// - Bit 0 goes first on line
// - Divisor write reloads 16-bit baud counter
package ulc_pkg;
  // Register offsets
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_IEN = 3'h1;
  localparam logic [2:0] OFF_IID = 3'h2;
  localparam logic [2:0] OFF_LCTL = 3'h3;
  localparam logic [2:0] OFF_MCTL = 3'h4;
  localparam logic [2:0] OFF_LSTAT = 3'h5;
  localparam logic [2:0] OFF_MSTAT = 3'h6;
  localparam logic [2:0] OFF_SCR = 3'h7;
  // Line control field positions
  localparam int LC_STOP = 2;
  localparam int LC_PAR_ON = 3;
  localparam int LC_EVEN = 4;
  localparam int LC_STICK = 5;
  localparam int LC_BREAK = 6;
  localparam int LC_BANK = 7;
  // Reset values
  localparam logic [7:0] LCTL_RST = 8'h00;
  localparam logic [3:0] IEN_RST = 4'h0;
  localparam logic [4:0] MCTL_RST = 5'h00;
  // Interrupt identification codes
  localparam logic [2:0] IID_NONE = 3'h1;
  localparam logic [2:0] IID_LINE = 3'h6;
  localparam logic [2:0] IID_RXD = 3'h4;
  localparam logic [2:0] IID_TX_HOLDING_EMPTY = 3'h2;
  // Timing in 16x ticks
  localparam logic [4:0] TK_BIT_END = 5'h0f;
  localparam logic [4:0] TK_STOP15_END = 5'h17;
  localparam logic [4:0] TK_STOP2_END = 5'h1f;
  localparam logic [3:0] TK_MID = 4'h7;
  localparam logic [3:0] TK_RX_END = 4'hf;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
    ulc_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
    ulc_rx_t;

  typedef struct packed {
    logic [7:0] lctl;
    logic [3:0] ien;
    logic [4:0] mctl;
    logic [7:0] scratch_byte;
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic [15:0] bcnt;
    logic [7:0] hold;
    logic hold_full;
    logic tx_holding_empty_pend;
    ulc_tx_t tx_st;
    logic [4:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tsr;
    logic tx_par;
    logic tx_line;
    logic tx_out;
    logic rx_s1;
    logic rx_s2;
    ulc_rx_t rx_st;
    logic [3:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_par;
    logic rx_zero;
    logic [7:0] rbuf;
    logic dr;
    logic oe;
    logic pe;
    logic fe;
    logic bi;
    logic [7:0] rdata;
    logic intr;
  } ulc_state_t;
endpackage

// *** ulc_uart.sv ***
`timescale 1ns/1ps
module ulc_uart
  import ulc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // CPU byte bus, strobes one cycle wide
  input wire logic sel_i,
  input wire logic [2:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // Serial line and interrupt
  input wire logic serial_rx_i,
  output logic serial_tx_pin_o,
  output logic intr_o
);

  ulc_state_t s;
  ulc_state_t n;

  // Pending interrupt by priority, gated by enables
  function automatic logic [2:0] iid_of(input ulc_state_t x);
    if (x.ien[2] && (x.oe || x.pe || x.fe || x.bi))
      return IID_LINE;
    else if (x.ien[0] && x.dr)
      return IID_RXD;
    else if (x.ien[1] && x.tx_holding_empty_pend)
      return IID_TX_HOLDING_EMPTY;
    else
      return IID_NONE;
  endfunction

  // Odd parity when even bit clear, fixed value under stick
  function automatic logic par_of(input logic [7:0] d, input logic [7:0] lc);
    if (lc[LC_STICK])
      return ~lc[LC_EVEN];
    else
      return lc[LC_EVEN] ? ^d : ~^d;
  endfunction

  // Outputs come straight from the state register
  assign rdata_o = s.rdata;
  assign serial_tx_pin_o = s.tx_out;
  assign intr_o = s.intr;

  // Next-state logic: bus, baud, transmitter, receiver
  always_comb
  begin
    logic tick;
    logic bank;
    logic [1:0] len;
    logic [2:0] last;
    logic [4:0] stop_end;
    logic [7:0] rx_data;
    logic [7:0] masked;
    logic thr_wr;
    logic tx_empty;
    // Defaults: every register holds unless a branch below moves it
    tick = 1'b0;
    stop_end = TK_BIT_END;
    n = s;
    bank = s.lctl[LC_BANK];
    len = s.lctl[1:0];
    last = {1'b1, len};
    // Character mask and right-aligned receive byte
    masked = 8'hff >> (2'd3 - len);
    rx_data = s.rx_sh >> (2'd3 - len);
    // Holding-register write this cycle; it must survive a load
    thr_wr = sel_i && wr_i && addr_i == OFF_DATA && !bank;
    tx_empty = ~s.hold_full && s.tx_st == TX_IDLE;
    // Stop length; 1.5 only for five-bit characters
    if (!s.lctl[LC_STOP])
      stop_end = TK_BIT_END;
    else if (len == 2'd0)
      stop_end = TK_STOP15_END;
    else
      stop_end = TK_STOP2_END;
    // Two-flop synchroniser; only the second stage is read
    n.rx_s1 = serial_rx_i;
    n.rx_s2 = s.rx_s1;

    // Baud counter, one tick per 16x period
    if (s.bcnt <= 16'h0001)
    begin
      n.bcnt = {s.div_hi, s.div_lo};
      tick = 1'b1;
    end
    else
      n.bcnt = s.bcnt - 16'h0001;

    // Register reads and their clear side effects
    if (sel_i && rd_i)
    begin
      case (addr_i)
        OFF_DATA:
        begin
          n.rdata = bank ? s.div_lo : s.rbuf;
          if (!bank)
            n.dr = 1'b0;
        end
        OFF_IEN: n.rdata = bank ? s.div_hi : {4'h0, s.ien};
        OFF_IID:
        begin
          // Reading the id drops a reported holding-empty
          n.rdata = {5'h00, iid_of(s)};
          if (iid_of(s) == IID_TX_HOLDING_EMPTY)
            n.tx_holding_empty_pend = 1'b0;
        end
        OFF_LCTL: n.rdata = s.lctl;
        OFF_MCTL: n.rdata = {3'h0, s.mctl};
        OFF_LSTAT:
        begin
          n.rdata = {1'b0, tx_empty, ~s.hold_full, s.bi, s.fe, s.pe,
                     s.oe, s.dr};
          // Error flags clear on read; a same-cycle receive wins
          n.oe = 1'b0;
          n.pe = 1'b0;
          n.fe = 1'b0;
          n.bi = 1'b0;
        end
        OFF_SCR: n.rdata = s.scratch_byte;
        default: n.rdata = 8'h00;
      endcase
    end

    // Register writes; status writes are ignored
    if (sel_i && wr_i)
    begin
      case (addr_i)
        OFF_DATA:
        begin
          if (bank)
          begin
            n.div_lo = wdata_i;
            n.bcnt = {s.div_hi, wdata_i};
          end
          else
          begin
            n.hold = wdata_i;
            n.hold_full = 1'b1;
            n.tx_holding_empty_pend = 1'b0;
          end
        end
        OFF_IEN:
        begin
          if (bank)
          begin
            n.div_hi = wdata_i;
            n.bcnt = {wdata_i, s.div_lo};
          end
          else
            n.ien = wdata_i[3:0];
        end
        OFF_LCTL: n.lctl = wdata_i;
        OFF_MCTL: n.mctl = wdata_i[4:0];
        OFF_SCR: n.scratch_byte = wdata_i;
        default: ;
      endcase
    end

    // Transmitter; runs regardless of break
    if (tick)
    begin
      n.tx_cnt = s.tx_cnt + 5'd1;
      case (s.tx_st)
        TX_IDLE:
        begin
          n.tx_cnt = 5'd0;
          n.tx_line = 1'b1;
        end
        TX_START:
          if (s.tx_cnt == TK_BIT_END)
          begin
            n.tx_cnt = 5'd0;
            n.tx_bit = 3'd0;
            n.tx_line = s.tsr[0];
            n.tx_st = TX_DATA;
          end
        TX_DATA:
          if (s.tx_cnt == TK_BIT_END)
          begin
            n.tx_cnt = 5'd0;
            n.tx_bit = s.tx_bit + 3'd1;
            n.tsr = s.tsr >> 1;
            n.tx_line = s.tsr[1];
            if (s.tx_bit == last)
            begin
              n.tx_st = s.lctl[LC_PAR_ON] ? TX_PAR : TX_STOP;
              n.tx_line = s.lctl[LC_PAR_ON] ? s.tx_par : 1'b1;
            end
          end
        TX_PAR:
          if (s.tx_cnt == TK_BIT_END)
          begin
            n.tx_cnt = 5'd0;
            n.tx_line = 1'b1;
            n.tx_st = TX_STOP;
          end
        TX_STOP:
          if (s.tx_cnt == stop_end)
          begin
            n.tx_cnt = 5'd0;
            n.tx_st = TX_IDLE;
          end
        default: n.tx_st = TX_IDLE;
      endcase
      // Load from idle or straight off the last stop tick, so
      // back-to-back frames get no extra idle tick between them
      if (s.hold_full && (s.tx_st == TX_IDLE ||
          (s.tx_st == TX_STOP && s.tx_cnt == stop_end)))
      begin
        n.tsr = s.hold;
        n.tx_par = par_of(s.hold & masked, s.lctl);
        n.hold_full = thr_wr; // A same-cycle write refills it
        n.tx_holding_empty_pend = 1'b1; // Set wins over a same-cycle clear
        n.tx_line = 1'b0;
        n.tx_cnt = 5'd0;
        n.tx_st = TX_START;
      end
    end
    // Break masks only the pin, not the shifter
    n.tx_out = n.tx_line & ~n.lctl[LC_BREAK];

    // Receiver, sampling mid-bit on 16x ticks
    if (tick)
    begin
      n.rx_cnt = s.rx_cnt + 4'd1;
      case (s.rx_st)
        RX_IDLE:
        begin
          n.rx_cnt = 4'd0;
          if (!s.rx_s2)
            n.rx_st = RX_START;
        end
        RX_START:
          if (s.rx_cnt == TK_MID)
          begin
            n.rx_cnt = 4'd0;
            n.rx_bit = 3'd0;
            n.rx_sh = 8'h00;
            n.rx_zero = 1'b1;
            // False start is dropped
            n.rx_st = s.rx_s2 ? RX_IDLE : RX_DATA;
          end
        RX_DATA:
          if (s.rx_cnt == TK_RX_END)
          begin
            n.rx_sh = {s.rx_s2, s.rx_sh[7:1]};
            n.rx_zero = s.rx_zero & ~s.rx_s2;
            n.rx_bit = s.rx_bit + 3'd1;
            if (s.rx_bit == last)
              n.rx_st = s.lctl[LC_PAR_ON] ? RX_PAR : RX_STOP;
          end
        RX_PAR:
          if (s.rx_cnt == TK_RX_END)
          begin
            n.rx_par = s.rx_s2;
            n.rx_zero = s.rx_zero & ~s.rx_s2;
            n.rx_st = RX_STOP;
          end
        RX_STOP:
          // First stop bit only; later ones look like idle
          if (s.rx_cnt == TK_RX_END)
          begin
            n.rbuf = rx_data;
            n.oe = n.oe | s.dr;
            n.dr = 1'b1;
            n.pe = n.pe | (s.lctl[LC_PAR_ON] &&
                   s.rx_par != par_of(rx_data, s.lctl));
            n.fe = n.fe | ~s.rx_s2;
            n.bi = n.bi | (s.rx_zero & ~s.rx_s2);
            n.rx_st = RX_IDLE;
          end
        default: n.rx_st = RX_IDLE;
      endcase
    end

    // Interrupt follows the next state so the pin is registered
    n.intr = (iid_of(n) != IID_NONE);
  end

  // State register with synchronous reset
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      s <= '0;
      s.lctl <= LCTL_RST;
      s.ien <= IEN_RST;
      s.mctl <= MCTL_RST;
      // Line and synchroniser idle high, so no false start
      s.tx_line <= 1'b1;
      s.tx_out <= 1'b1;
      s.rx_s1 <= 1'b1;
      s.rx_s2 <= 1'b1;
    end
    else
      s <= n;
  end

endmodule

// *** ulc_far_end.sv ***
`timescale 1ns/1ps
module ulc_far_end (
  // Clock
  input wire logic clk_sys_i,
  // Line pair seen from the far end
  input wire logic line_i,
  output logic line_o
);
  // Echo mode: each frame comes back one clock later, so one
  // bench checks both directions without a second encoder
  initial line_o = 1'b1;
  always @(posedge clk_sys_i)
  begin
    line_o <= line_i;
  end
endmodule

// *** ulc_uart_sva.sv ***
`timescale 1ns/1ps
module ulc_uart_sva
  import ulc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // CPU bus
  input wire logic sel_i,
  input wire logic [2:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  // Line and interrupt
  input wire logic serial_rx_i,
  input wire logic serial_tx_pin_o,
  input wire logic intr_o
);
  logic [7:0] lc, scratch_byte, dl;
  logic [3:0] ien;
  wire rq = sel_i & rd_i & !wr_i;
  wire brk = lc[6];
  wire quiet = ien == 4'h0;
  // Bus-side copy of line control, enables, scratch and divisor low
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      lc <= LCTL_RST;
      ien <= IEN_RST;
      dl <= 8'h00;
      scratch_byte <= 8'h00;
    end
    else if (sel_i && wr_i)
    begin
      if (addr_i == OFF_LCTL) lc <= wdata_i;
      if (addr_i == OFF_SCR) scratch_byte <= wdata_i;
      if (addr_i == OFF_DATA && lc[7]) dl <= wdata_i;
      if (addr_i == OFF_IEN && !lc[7]) ien <= wdata_i[3:0];
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  property p_rst_idle;
    $fell(sys_rst_i) |-> serial_tx_pin_o && !intr_o && rdata_o == 8'h00;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("reset state");
  property p_lc_rd;
    rq && addr_i == OFF_LCTL |=> rdata_o == $past(lc);
  endproperty
  a_lc_rd: assert property (p_lc_rd) else $error("ctl read");
  property p_scr_rd;
    rq && addr_i == OFF_SCR |=> rdata_o == $past(scratch_byte);
  endproperty
  a_scr_rd: assert property (p_scr_rd) else $error("scratch");
  property p_ien_rd;
    rq && addr_i == OFF_IEN && !lc[7] |=> rdata_o == {4'h0, $past(ien)};
  endproperty
  a_ien_rd: assert property (p_ien_rd) else $error("enable read");
  property p_dl_rd;
    rq && addr_i == OFF_DATA && lc[7] |=> rdata_o == $past(dl);
  endproperty
  a_dl_rd: assert property (p_dl_rd) else $error("divisor read");
  property p_brk;
    brk && $past(brk) && $past(brk, 2) |-> !serial_tx_pin_o;
  endproperty
  a_brk: assert property (p_brk) else $error("break level");
  property p_quiet;
    quiet && $past(quiet) && $past(quiet, 2) |-> !intr_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("masked intr");
  // Every line level lasts at least 8 clocks once it changes
  property p_bit_len;
    $changed(serial_tx_pin_o) |=> $stable(serial_tx_pin_o) [*7];
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit width");
  c_bank: cover property (sel_i && wr_i && addr_i == OFF_DATA && lc[7]);
  c_brk: cover property (brk && !serial_tx_pin_o);
  c_intr: cover property ($rose(intr_o));
endmodule

// *** uart_line_control_regmap_tb.sv ***
`timescale 1ns/1ps
module uart_line_control_regmap_tb;
  import ulc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic sel_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic rd_i = 1'b0;
  logic wr_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o, rv;
  logic serial_rx_i, serial_tx_pin_o, intr_o;
  logic logging = 1'b0;
  logic tx_log[$];
  int mismatches = 0;
  int checked = 0;
  // Line control, divisor, first byte, second byte
  logic [7:0] cfg [6][4] = '{'{8'h00, 8'h01, 8'h15, 8'h0a},
    '{8'h04, 8'h01, 8'h1e, 8'h01}, '{8'h0f, 8'h02, 8'h96, 8'h5a},
    '{8'h1a, 8'h01, 8'h35, 8'h7f}, '{8'h29, 8'h03, 8'h2c, 8'h33},
    '{8'h3b, 8'h01, 8'hc3, 8'h80}};
  logic [7:0] ien_v [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00};
  // Clock
  always #2.5 clk_sys_i = ~clk_sys_i;
  // Line history, one entry per clock, for frame timing
  always @(posedge clk_sys_i)
  begin
    if (logging) tx_log.push_back(serial_tx_pin_o);
  end
  ulc_uart i_ulc_uart (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .sel_i(sel_i), .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .serial_rx_i(serial_rx_i),
    .serial_tx_pin_o(serial_tx_pin_o), .intr_o(intr_o));
  ulc_far_end i_ulc_far_end (.clk_sys_i(clk_sys_i),
    .line_i(serial_tx_pin_o), .line_o(serial_rx_i));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
    input string what);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // One bus cycle; strobe held for exactly one edge
  task automatic acc(input logic w, input logic [2:0] a,
    input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    sel_i = 1'b1;
    wr_i = w;
    rd_i = !w;
    addr_i = a;
    wdata_i = d;
    @(posedge clk_sys_i);
    #1;
    sel_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    rv = rdata_o;
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] exp,
    input string what);
    acc(1'b0, a, 8'h00);
    chk(rv, exp, what);
  endtask
  // Polling clears the error flags, so only used where none matter
  task automatic wait_ls(input int b);
    for (int n = 0; n < 3000; n++)
    begin
      acc(1'b0, OFF_LSTAT, 8'h00);
      if (rv[b] === 1'b1) return;
    end
    mismatches++;
    wrap_up();
  endtask
  task automatic run_frames(input logic [7:0] lc, dv, a, b);
    int n, p, bt, s, e;
    logic [11:0] f;
    n = 5 + lc[1:0];
    p = lc[3];
    bt = 16 * dv;
    acc(1'b1, OFF_LCTL, 8'h80);
    acc(1'b1, OFF_DATA, dv);
    acc(1'b1, OFF_IEN, 8'h00);
    rc(OFF_DATA, dv, "divisor low");
    acc(1'b1, OFF_LCTL, lc);
    rc(OFF_LCTL, lc, "line control");
    tx_log.delete();
    logging = 1'b1;
    acc(1'b1, OFF_DATA, a);
    wait_ls(5);
    acc(1'b1, OFF_DATA, b);
    repeat (2 * bt * (n + p + 3) + 40) @(posedge clk_sys_i);
    logging = 1'b0;
    s = 0;
    while (s < tx_log.size() && tx_log[s] !== 1'b0) s++;
    f = ~12'h001;
    for (int k = 0; k < n; k++) f[k + 1] = a[k];
    if (p) f[n + 1] = lc[5] ? ~lc[4] : ^(a & (8'hff >> (8 - n))) ^ ~lc[4];
    for (int k = 0; k < n + p + 2; k++)
      chk(8'(tx_log[s + k * bt + bt / 2]), 8'(f[k]), "bit");
    e = s + bt * (n + p + 1) + dv * (lc[2] ? (n == 5 ? 24 : 32) : 16);
    chk(8'({tx_log[e - 1], tx_log[e]}), 8'h02, "next start");
    foreach (ien_v[i])
    begin
      acc(1'b1, OFF_IEN, ien_v[i]);
      repeat (2) @(posedge clk_sys_i);
      chk(8'(intr_o), 8'(|ien_v[i][2:0]), "intr");
    end
    rc(OFF_LSTAT, 8'h63, "line status");
    rc(OFF_DATA, b & (8'hff >> (8 - n)), "rx byte");
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    #1;
    sys_rst_i = 1'b0;
    rc(OFF_LCTL, 8'h00, "ctl reset");
    rc(OFF_IEN, 8'h00, "enable reset");
    rc(OFF_LSTAT, 8'h60, "status reset");
    rc(OFF_IID, 8'h01, "id reset");
    acc(1'b1, OFF_LCTL, 8'h80);
    acc(1'b1, OFF_IEN, 8'h12);
    acc(1'b1, OFF_LCTL, 8'h00);
    acc(1'b1, OFF_IEN, 8'hff);
    rc(OFF_IEN, 8'h0f, "enable bits");
    acc(1'b1, OFF_SCR, 8'ha5);
    rc(OFF_SCR, 8'ha5, "scratch");
    acc(1'b1, OFF_LCTL, 8'h80);
    rc(OFF_IEN, 8'h12, "divisor high");
    foreach (cfg[i]) run_frames(cfg[i][0], cfg[i][1], cfg[i][2], cfg[i][3]);
    // Clean break: pad byte, break on next empty, release when all empty
    acc(1'b1, OFF_DATA, 8'h00);
    wait_ls(5);
    acc(1'b1, OFF_LCTL, 8'h43);
    acc(1'b1, OFF_DATA, 8'hff);
    wait_ls(6);
    chk(8'(serial_tx_pin_o), 8'h00, "break level");
    acc(1'b1, OFF_LCTL, 8'h03);
    repeat (2) @(posedge clk_sys_i);
    chk(8'(serial_tx_pin_o), 8'h01, "break end");
    wrap_up();
  end
endmodule
bind ulc_uart ulc_uart_sva i_ulc_uart_sva (.clk_sys_i(clk_sys_i),
  .sys_rst_i(sys_rst_i), .sel_i(sel_i), .addr_i(addr_i), .rd_i(rd_i),
  .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .serial_rx_i(serial_rx_i), .serial_tx_pin_o(serial_tx_pin_o),
  .intr_o(intr_o));
